// ==== hdl/esa_pkg.sv ====
`default_nettype none
package esa_pkg;

  // Area decode window and pin widths
  localparam logic [31:0] AREA4_BASE = 32'h0400_0000; // see RULE_01
  localparam logic [31:0] AREA4_LAST = 32'h04FF_FFFF;
  localparam int ADDR_PINS = 21;
  localparam int DATA_BITS = 16;

  // Access timing, in external bus cycles counted from the access start
  localparam logic [3:0] SELECT_ASSERT_DELAY = 4'h0;
  localparam logic [3:0] READ_STROBE_DELAY = 4'h0; // see RULE_22
  localparam logic [3:0] READ_WAIT_COUNT = 4'h3;
  localparam logic [3:0] READ_SELECT_EXTENSION = 4'h1; // see RULE_06
  localparam logic [3:0] WRITE_STROBE_DELAY = 4'h1; // see RULE_10
  localparam logic [3:0] WRITE_DATA_DRIVE_DELAY = 4'h1;
  localparam logic [3:0] WRITE_WAIT_COUNT = 4'h2;
  localparam logic [3:0] WRITE_SELECT_EXTENSION = 4'h1; // see RULE_07
  localparam logic [3:0] WRITE_DATA_HOLD_EXTENSION = 4'h1;
  localparam logic [3:0] READ_RECOVERY = 4'h0;
  localparam logic [3:0] WRITE_RECOVERY = 4'h0;
  localparam logic [3:0] READ_LAST = READ_WAIT_COUNT + READ_SELECT_EXTENSION;
  localparam logic [3:0] WRITE_LAST = WRITE_WAIT_COUNT + WRITE_SELECT_EXTENSION; // see RULE_21
  localparam logic [3:0] WRITE_DATA_LAST = WRITE_WAIT_COUNT + WRITE_DATA_HOLD_EXTENSION;

  // Cycles a requester may wait for the bus before a timeout error
  localparam logic [7:0] TIMEOUT_CYCLES = 8'h40;

  // Register map
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam int CTRL_BYTE_MODE_BIT = 0;
  localparam int CTRL_BIG_ENDIAN_BIT = 1;
  localparam int CTRL_IRQ_EN_BIT = 2;
  localparam int CTRL_LEVEL_LSB = 4;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_ERR_BIT = 1;
  localparam int STATUS_TMO_BIT = 2;
  localparam int STATUS_ADDR_BIT = 3;
  localparam logic [7:0] CTRL_RESET = 8'h14;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum {ESA_IDLE, ESA_READ, ESA_WRITE} esa_state_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [15:0] wdata;
    logic [1:0] be;
  } esa_req_type;

  typedef struct packed {
    logic done;
    logic err;
    logic [15:0] rdata;
  } esa_resp_type;

  typedef struct packed {
    logic [20:0] addr;
    logic area4_select_n;
    logic read_strobe_n;
    logic write_strobe_n;
    logic low_byte_enable_n;
    logic high_byte_enable_n;
    logic [15:0] dout;
    logic data_oe_n;
  } esa_pin_type;

endpackage : esa_pkg
`default_nettype wire

// ==== hdl/esa_area_ctrl.sv ====
// What this block does
// RULE_01: Only accesses inside the area-4 window assert the area select.
// RULE_02: Sixteen-bit data path with one write strobe and two byte enables.
// RULE_03: Byte order on the pins follows the selected endian mode.
// RULE_04: Reads hold the read strobe through three wait cycles.
// RULE_05: Writes hold the write strobe through two wait cycles.
// RULE_06: Select stays asserted one cycle after the read strobe ends.
// RULE_07: Select stays asserted one cycle after the write strobe ends.
// RULE_08: Write data stays driven one cycle after the write strobe ends.
// RULE_09: Read strobe asserts in the first cycle of a read.
// RULE_10: Write strobe asserts one cycle after the write starts.
// RULE_11: Write data is driven from one cycle after the write starts.
// RULE_12: Select and address appear together in the first access cycle.
// RULE_13: No recovery cycles between consecutive accesses.
// RULE_14: Address goes out on twenty-one address pins.
// RULE_15: Invalid address and wait timeout both flag a bus error.
// RULE_16: A bus error raises the interrupt when enabled, at level one; irq_level is the writable CTRL level field, one after reset.
// RULE_17: Requesters are granted by fixed, non-rotating priority.
// RULE_18: Shared upper pin acts as the upper byte enable in single strobe mode and as the upper write strobe in byte strobe mode.
// RULE_19: Single strobe mode: one strobe, byte enables mark valid bytes.
// RULE_20: Byte strobe mode: enables unused, one write strobe per byte.
// RULE_21: Write strobe drops after the wait; select drops with data hold end.
// RULE_22: Reads start with address, select and read strobe together.
// RULE_23: Read strobe drops after the wait and read data is captured.
// RULE_24: Single transfers of fixed length; no external wait input.
// RULE_25: Memory drives read data in time and latches write data.
`timescale 1ns/1ps
`default_nettype none
module esa_area_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire esa_pkg::esa_req_type req_hi,
  input wire esa_pkg::esa_req_type req_lo,
  output esa_pkg::esa_resp_type resp_hi,
  output esa_pkg::esa_resp_type resp_lo,
  output esa_pkg::esa_pin_type mem_pins,
  input wire logic [15:0] mem_data_in,
  output logic bus_error_irq,
  output logic [3:0] irq_level
);

  function automatic logic in_window(input logic [31:0] a);
    in_window = (a >= esa_pkg::AREA4_BASE) && (a <= esa_pkg::AREA4_LAST);
  endfunction : in_window

  function automatic logic [15:0] lane_swap(input logic [15:0] d, input logic big);
    lane_swap = big ? {d[7:0], d[15:8]} : d;
  endfunction : lane_swap

  function automatic logic reg_known(input logic [7:0] a);
    reg_known = (a == esa_pkg::CTRL_OFFSET) || (a == esa_pkg::STATUS_OFFSET);
  endfunction : reg_known

  function automatic esa_pkg::esa_pin_type pin_drive(input esa_pkg::esa_state_type st,
      input logic [3:0] cyc, input esa_pkg::esa_req_type acc, input logic byte_mode,
      input logic big);
    esa_pkg::esa_pin_type p;
    logic sel;
    logic rd_on;
    logic wr_on;
    logic dat_on;
    logic [1:0] be;
    be = big ? {acc.be[0], acc.be[1]} : acc.be; // see RULE_03
    sel = (st != esa_pkg::ESA_IDLE) && (cyc >= esa_pkg::SELECT_ASSERT_DELAY);
    rd_on = (st == esa_pkg::ESA_READ) && (cyc >= esa_pkg::READ_STROBE_DELAY)
      && (cyc <= esa_pkg::READ_WAIT_COUNT); // see RULE_04
    wr_on = (st == esa_pkg::ESA_WRITE) && (cyc >= esa_pkg::WRITE_STROBE_DELAY)
      && (cyc <= esa_pkg::WRITE_WAIT_COUNT); // see RULE_05
    dat_on = (st == esa_pkg::ESA_WRITE) && (cyc >= esa_pkg::WRITE_DATA_DRIVE_DELAY)
      && (cyc <= esa_pkg::WRITE_DATA_LAST); // see RULE_08
    p.addr = acc.addr[esa_pkg::ADDR_PINS-1:0]; // see RULE_14
    p.area4_select_n = !sel; // see RULE_12
    p.read_strobe_n = !rd_on; // see RULE_09
    if (byte_mode) begin
      // Enables idle high; the shared upper pin becomes the upper strobe
      p.write_strobe_n = !(wr_on && be[0]); // see RULE_20
      p.high_byte_enable_n = !(wr_on && be[1]);
      p.low_byte_enable_n = 1'b1;
    end else begin
      p.write_strobe_n = !wr_on; // see RULE_19
      p.low_byte_enable_n = !(sel && be[0]); // see RULE_02
      p.high_byte_enable_n = !(sel && be[1]); // see RULE_18
    end
    p.dout = lane_swap(acc.wdata, big);
    p.data_oe_n = !dat_on; // see RULE_11
    pin_drive = p;
  endfunction : pin_drive

  esa_pkg::esa_state_type state_reg, state_next;
  logic [3:0] cyc_reg, cyc_next;
  esa_pkg::esa_req_type cur_reg, cur_next;
  logic owner_reg, owner_next;
  esa_pkg::esa_req_type req [2];
  logic [1:0] eligible;
  logic grant_valid;
  logic grant_idx;
  logic take;
  logic take_bad;
  logic ext_last;
  logic [1:0] tmo_fire;
  logic [7:0] wait_cnt_reg [2];
  esa_pkg::esa_resp_type resp_reg [2];
  esa_pkg::esa_pin_type pins_reg;
  logic ext_start_reg;
  logic [15:0] din_meta_reg;
  logic [15:0] din_sync_reg;
  logic [7:0] ctrl_reg;
  logic err_flag_reg, err_flag_next;
  logic tmo_flag_reg;
  logic addr_flag_reg;
  logic irq_reg;
  logic err_event;
  logic err_clear;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic aw_full_reg;
  logic w_full_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic reg_write;

  assign req[0] = req_hi;
  assign req[1] = req_lo;

  assign ext_last = ((state_reg == esa_pkg::ESA_READ) && (cyc_reg == esa_pkg::READ_LAST))
    || ((state_reg == esa_pkg::ESA_WRITE) && (cyc_reg == esa_pkg::WRITE_LAST));

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      // A request already answered or in service is not offered again
      eligible[i] = req[i].valid && !resp_reg[i].done
        && !((state_reg != esa_pkg::ESA_IDLE) && (owner_reg == 1'(i)));
    end
    grant_valid = eligible[0] || eligible[1];
    grant_idx = !eligible[0]; // see RULE_17
    take = grant_valid && ((state_reg == esa_pkg::ESA_IDLE) || ext_last);
    take_bad = take && !in_window(req[grant_idx].addr); // see RULE_15
    for (int i = 0; i < 2; i++) begin
      tmo_fire[i] = eligible[i] && !(take && (grant_idx == 1'(i)))
        && (wait_cnt_reg[i] == esa_pkg::TIMEOUT_CYCLES);
    end
  end

  always_comb begin
    state_next = state_reg;
    cyc_next = cyc_reg;
    cur_next = cur_reg;
    owner_next = owner_reg;
    if ((state_reg != esa_pkg::ESA_IDLE) && !ext_last) begin
      cyc_next = cyc_reg + 4'h1; // see RULE_24
    end else begin
      state_next = esa_pkg::ESA_IDLE;
      cyc_next = 4'h0;
      if (take && !take_bad) begin
        // Granted in the last cycle of the previous access, starts in the cycle after: no gap
        state_next = req[grant_idx].write ? esa_pkg::ESA_WRITE : esa_pkg::ESA_READ; // see RULE_13
        cur_next = req[grant_idx];
        owner_next = grant_idx;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= esa_pkg::ESA_IDLE;
      cyc_reg <= 4'h0;
      cur_reg <= '0;
      owner_reg <= 1'b0;
      ext_start_reg <= 1'b0;
      pins_reg <= pin_drive(esa_pkg::ESA_IDLE, 4'h0, '0, 1'b0, 1'b0);
    end else begin
      state_reg <= state_next;
      cyc_reg <= cyc_next;
      cur_reg <= cur_next;
      owner_reg <= owner_next;
      ext_start_reg <= take && !take_bad;
      pins_reg <= pin_drive(state_next, cyc_next, cur_next,
        ctrl_reg[esa_pkg::CTRL_BYTE_MODE_BIT], ctrl_reg[esa_pkg::CTRL_BIG_ENDIAN_BIT]);
    end
  end

  // Two stages on the data pins; capture sees the level of cycle 2
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      din_meta_reg <= 16'h0000;
      din_sync_reg <= 16'h0000;
    end else begin
      din_meta_reg <= mem_data_in;
      din_sync_reg <= din_meta_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 2; i++) begin
        resp_reg[i] <= '0;
        wait_cnt_reg[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        resp_reg[i].done <= (ext_last && (owner_reg == 1'(i)))
          || (take_bad && (grant_idx == 1'(i))) || tmo_fire[i];
        resp_reg[i].err <= (take_bad && (grant_idx == 1'(i))) || tmo_fire[i];
        if (ext_last && (owner_reg == 1'(i)) && (state_reg == esa_pkg::ESA_READ)) begin
          resp_reg[i].rdata <= lane_swap(din_sync_reg,
            ctrl_reg[esa_pkg::CTRL_BIG_ENDIAN_BIT]); // see RULE_23
        end
        if (eligible[i] && !(take && (grant_idx == 1'(i))) && !tmo_fire[i]) begin
          wait_cnt_reg[i] <= wait_cnt_reg[i] + 8'h01;
        end else begin
          wait_cnt_reg[i] <= 8'h00;
        end
      end
    end
  end

  // Error flags: a new error beats a clear in the same cycle
  assign err_event = take_bad || (tmo_fire != 2'b00);
  assign reg_write = aw_full_reg && w_full_reg && !bvalid_reg;
  assign err_clear = reg_write && (aw_addr_reg == esa_pkg::STATUS_OFFSET) && w_strb_reg[0]
    && w_data_reg[esa_pkg::STATUS_ERR_BIT];
  assign err_flag_next = err_event || (err_flag_reg && !err_clear);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_flag_reg <= 1'b0;
      tmo_flag_reg <= 1'b0;
      addr_flag_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      err_flag_reg <= err_flag_next; // see RULE_15
      tmo_flag_reg <= (tmo_fire != 2'b00) || (tmo_flag_reg && !err_clear);
      addr_flag_reg <= take_bad || (addr_flag_reg && !err_clear);
      irq_reg <= err_flag_next && ctrl_reg[esa_pkg::CTRL_IRQ_EN_BIT]; // see RULE_16
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= esa_pkg::CTRL_RESET;
    end else if (reg_write && (aw_addr_reg == esa_pkg::CTRL_OFFSET) && w_strb_reg[0]) begin
      ctrl_reg <= w_data_reg[7:0];
    end
  end

  // Write channel: address and data are taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= esa_pkg::AXI_OKAY;
    end else begin
      if (s_axi_awvalid && awready_reg) begin
        aw_addr_reg <= s_axi_awaddr;
        aw_full_reg <= 1'b1;
        awready_reg <= 1'b0;
      end
      if (s_axi_wvalid && wready_reg) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_full_reg <= 1'b1;
        wready_reg <= 1'b0;
      end
      if (reg_write) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= reg_known(aw_addr_reg) ? esa_pkg::AXI_OKAY : esa_pkg::AXI_SLVERR;
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= esa_pkg::AXI_OKAY;
    end else if (s_axi_arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= reg_known(s_axi_araddr) ? esa_pkg::AXI_OKAY : esa_pkg::AXI_SLVERR;
      rdata_reg <= 32'h0000_0000;
      if (s_axi_araddr == esa_pkg::CTRL_OFFSET) begin
        rdata_reg[7:0] <= ctrl_reg;
      end else if (s_axi_araddr == esa_pkg::STATUS_OFFSET) begin
        rdata_reg[esa_pkg::STATUS_BUSY_BIT] <= state_reg != esa_pkg::ESA_IDLE;
        rdata_reg[esa_pkg::STATUS_ERR_BIT] <= err_flag_reg;
        rdata_reg[esa_pkg::STATUS_TMO_BIT] <= tmo_flag_reg;
        rdata_reg[esa_pkg::STATUS_ADDR_BIT] <= addr_flag_reg;
      end
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign resp_hi = resp_reg[0];
  assign resp_lo = resp_reg[1];
  assign mem_pins = pins_reg;
  assign bus_error_irq = irq_reg;
  assign irq_level = ctrl_reg[esa_pkg::CTRL_LEVEL_LSB+:4];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_read_body;
    (!mem_pins.read_strobe_n && !mem_pins.area4_select_n) [*4]
      ##1 (mem_pins.read_strobe_n && !mem_pins.area4_select_n);
  endsequence

  sequence s_write_body;
    (mem_pins.write_strobe_n && mem_pins.data_oe_n && !mem_pins.area4_select_n)
      ##1 (!mem_pins.write_strobe_n && !mem_pins.data_oe_n) [*2]
      ##1 (mem_pins.write_strobe_n && !mem_pins.data_oe_n && !mem_pins.area4_select_n);
  endsequence

  a_read_timing: assert property ( // see RULE_04
    ext_start_reg && !cur_reg.write |-> s_read_body ##1 (mem_pins.area4_select_n || ext_start_reg))
    else $error("read strobe or select timing wrong");

  a_write_timing: assert property ( // see RULE_21
    ext_start_reg && cur_reg.write && !ctrl_reg[esa_pkg::CTRL_BYTE_MODE_BIT]
      |-> s_write_body ##1 ((mem_pins.area4_select_n && mem_pins.data_oe_n) || ext_start_reg))
    else $error("write strobe, data or select timing wrong");

  a_select_window: assert property ( // see RULE_01
    !mem_pins.area4_select_n |-> in_window(cur_reg.addr))
    else $error("select asserted outside the area window");

  a_bad_addr_err: assert property ( // see RULE_15
    take_bad |=> err_flag_reg && ($past(grant_idx) ? resp_lo.err : resp_hi.err)
      && !ext_start_reg)
    else $error("invalid address not flagged");

  a_no_recovery: assert property ( // see RULE_13
    ext_last && take && !take_bad |=> ext_start_reg && !mem_pins.area4_select_n)
    else $error("gap inserted between accesses");

  a_fixed_priority: assert property ( // see RULE_17
    take && eligible[0] |=> owner_reg == 1'b0 || $past(take_bad))
    else $error("lower requester won against higher");

  a_irq_follows: assert property ( // see RULE_16
    $rose(err_flag_reg) && ctrl_reg[esa_pkg::CTRL_IRQ_EN_BIT] |-> bus_error_irq && irq_level == 4'h1
      || $past(ctrl_reg[esa_pkg::CTRL_LEVEL_LSB+:4]) != 4'h1)
    else $error("bus error did not raise interrupt");

  a_byte_strobe_en: assert property ( // see RULE_20
    ctrl_reg[esa_pkg::CTRL_BYTE_MODE_BIT] && $stable(ctrl_reg) && !mem_pins.area4_select_n
      |-> mem_pins.low_byte_enable_n)
    else $error("byte enable driven in byte strobe mode");

  a_addr_stable: assert property ( // see RULE_12
    !mem_pins.area4_select_n && !ext_start_reg |-> $stable(mem_pins.addr))
    else $error("address moved during an access");

endmodule : esa_area_ctrl
`default_nettype wire

// ==== bench/esa_sram_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module esa_sram_model (
  input wire logic aclk,
  input wire logic byte_mode,
  input wire esa_pkg::esa_pin_type pins,
  output logic [15:0] rd_data
);
  logic [15:0] mem [logic [20:0]];
  logic [15:0] last_q = 16'h0000;
  logic [15:0] old_w;
  logic [15:0] wd;
  logic rd_on;
  logic wr_lo;
  logic wr_hi;
  assign rd_on = !pins.area4_select_n && !pins.read_strobe_n;
  assign wr_lo = !pins.area4_select_n && !pins.write_strobe_n
                 && (byte_mode || !pins.low_byte_enable_n);
  assign wr_hi = !pins.area4_select_n && (byte_mode ? !pins.high_byte_enable_n
                 : (!pins.write_strobe_n && !pins.high_byte_enable_n));
  // Released bus shows the inverse of the last word so stale data never passes
  always @(*) begin
    if (rd_on) begin
      rd_data = mem.exists(pins.addr) ? mem[pins.addr] : 16'h5A5A;
    end else begin
      rd_data = ~last_q;
    end
  end
  always @(posedge aclk) begin
    if (rd_on) last_q <= rd_data;
    if (wr_lo || wr_hi) begin
      old_w = mem.exists(pins.addr) ? mem[pins.addr] : 16'h0000;
      // Undriven data lines store garbage
      wd = pins.data_oe_n ? ~pins.dout : pins.dout;
      mem[pins.addr] = {wr_hi ? wd[15:8] : old_w[15:8], wr_lo ? wd[7:0] : old_w[7:0]};
    end
  end
endmodule : esa_sram_model
`default_nettype wire

// ==== bench/esa_area_ctrl_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module esa_area_ctrl_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  esa_pkg::esa_req_type rq_hi = '0;
  esa_pkg::esa_req_type rq_lo = '0;
  esa_pkg::esa_resp_type rs_hi, rs_lo;
  esa_pkg::esa_pin_type pins;
  logic [15:0] mem_rd;
  logic bus_error_irq;
  logic [3:0] irq_level;
  logic bmode = 1'b0, bigm = 1'b0;
  int n_mismatch = 0, check_count = 0;
  logic [31:0] lfsr = 32'h4E59;
  logic [15:0] ref_mem [logic [20:0]];

  always #2 aclk = ~aclk;

  esa_area_ctrl dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .req_hi(rq_hi), .req_lo(rq_lo),
    .resp_hi(rs_hi), .resp_lo(rs_lo), .mem_pins(pins), .mem_data_in(mem_rd),
    .bus_error_irq(bus_error_irq), .irq_level(irq_level));

  esa_sram_model model_u (.aclk(aclk), .byte_mode(bmode), .pins(pins), .rd_data(mem_rd));

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd

  task final_report();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  task tmo();
    n_mismatch++;
    final_report();
  endtask : tmo

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task settle();
    repeat (3) @(posedge aclk);
    #1;
  endtask : settle

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 50) tmo();
    chk(s_axi_bresp, er);
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 50) tmo();
    chk(s_axi_rdata, d);
    chk(s_axi_rresp, er);
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  // Pins of access cycle c, as worked out from the programmed counts
  task automatic pin_chk(input bit wr, input bit err, input int c, input logic [1:0] pb,
      input logic [15:0] pd, input logic [20:0] pa);
    bit act;
    bit stb;
    act = !err && c <= (wr ? 3 : 4);
    stb = wr && (c == 1 || c == 2);
    chk(pins.area4_select_n, !act);
    if (act) chk(pins.addr, pa);
    chk(pins.read_strobe_n, !(act && !wr && c <= 3));
    chk(pins.data_oe_n, !(act && wr && c >= 1));
    chk(pins.write_strobe_n, !(act && stb && (!bmode || pb[0])));
    if (act && !(bmode && !wr)) begin
      chk(pins.low_byte_enable_n, bmode || !pb[0]);
      chk(pins.high_byte_enable_n, bmode ? (!stb || !pb[1]) : !pb[1]);
    end
    if (act && wr && c >= 1) chk(pins.dout, pd);
  endtask : pin_chk

  // Chained calls keep valid high and skip the leading edge, so the next request is set at the edge where done is seen
  task automatic do_req(input bit hi, input bit wr, input logic [31:0] a, input logic [15:0] d,
      input logic [1:0] be, input bit err, input int exp_n, input bit pc, input bit chain);
    int n;
    logic [15:0] ex;
    esa_pkg::esa_resp_type r;
    esa_pkg::esa_req_type q;
    q = {1'b1, wr, a, d, be};
    if (!chain) @(posedge aclk);
    if (hi) rq_hi <= q;
    else rq_lo <= q;
    for (n = 1; n < 200; n++) begin
      @(posedge aclk);
      r = hi ? rs_hi : rs_lo;
      if (pc && n >= 2 && n <= exp_n) pin_chk(wr, err, n - 2, bigm ? {be[0], be[1]} : be,
          bigm ? {d[7:0], d[15:8]} : d, a[20:0]);
      if (r.done) break;
    end
    if (n == 200) tmo();
    if (exp_n > 0) chk(n, exp_n);
    chk(r.err, err);
    ex = ref_mem.exists(a[20:0]) ? ref_mem[a[20:0]] : 16'h0000;
    if (!err && !wr) chk(r.rdata, ex);
    if (!err && wr) ref_mem[a[20:0]] = {be[1] ? d[15:8] : ex[15:8], be[0] ? d[7:0] : ex[7:0]};
    if (!chain && hi) rq_hi <= '0;
    if (!chain && !hi) rq_lo <= '0;
  endtask : do_req

  initial begin
    logic [31:0] a;
    logic [31:0] rv;
    int m;
    int i;
    int k;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    chk({pins.area4_select_n, pins.read_strobe_n, pins.write_strobe_n, pins.data_oe_n}, 4'hF);
    chk(irq_level, 4'h1);
    axi_rd(esa_pkg::CTRL_OFFSET, 32'h14, esa_pkg::AXI_OKAY);
    axi_rd(esa_pkg::STATUS_OFFSET, 32'h0, esa_pkg::AXI_OKAY);
    axi_wr(8'h08, 32'hFF, esa_pkg::AXI_SLVERR);
    axi_rd(8'h08, 32'h0, esa_pkg::AXI_SLVERR);
    axi_wr(esa_pkg::CTRL_OFFSET, 32'h34, esa_pkg::AXI_OKAY);
    chk(irq_level, 4'h3);
    for (m = 0; m < 4; m++) begin
      axi_wr(esa_pkg::CTRL_OFFSET, 32'h14 | m, esa_pkg::AXI_OKAY);
      axi_rd(esa_pkg::CTRL_OFFSET, 32'h14 | m, esa_pkg::AXI_OKAY);
      bmode <= m[0];
      bigm <= m[1];
      for (i = 0; i < 6; i++) begin
        rv = rnd();
        a = i == 0 ? 32'h0400_0000 : i == 1 ? 32'h04FF_FFFE : {8'h04, rv[23:1], 1'b0};
        do_req(i[0], 1'b1, a, rv[15:0], 2'h3, 1'b0, 6, 1'b1, 1'b0);
        do_req(!i[0], 1'b1, a, rv[31:16], i[1] ? 2'h1 : 2'h2, 1'b0, 6, 1'b1, 1'b0);
        do_req(i[0], 1'b0, a, 16'h0000, 2'h3, 1'b0, 7, 1'b1, 1'b0);
      end
    end
    axi_wr(esa_pkg::CTRL_OFFSET, 32'h14, esa_pkg::AXI_OKAY);
    bmode <= 1'b0;
    bigm <= 1'b0;
    do_req(1'b1, 1'b0, 32'h0500_0000, 16'h0000, 2'h3, 1'b1, 2, 1'b1, 1'b0);
    do_req(1'b0, 1'b1, 32'h03FF_FFFE, 16'h1234, 2'h3, 1'b1, 2, 1'b1, 1'b0);
    axi_rd(esa_pkg::STATUS_OFFSET, 32'h0A, esa_pkg::AXI_OKAY);
    chk(bus_error_irq, 1'b1);
    axi_wr(esa_pkg::STATUS_OFFSET, 32'h02, esa_pkg::AXI_OKAY);
    settle();
    chk(bus_error_irq, 1'b0);
    axi_wr(esa_pkg::CTRL_OFFSET, 32'h10, esa_pkg::AXI_OKAY);
    do_req(1'b1, 1'b1, 32'h0000_0000, 16'h0000, 2'h3, 1'b1, 2, 1'b1, 1'b0);
    settle();
    chk(bus_error_irq, 1'b0);
    axi_wr(esa_pkg::CTRL_OFFSET, 32'h14, esa_pkg::AXI_OKAY);
    settle();
    chk(bus_error_irq, 1'b1);
    axi_wr(esa_pkg::STATUS_OFFSET, 32'h02, esa_pkg::AXI_OKAY);
    fork
      do_req(1'b1, 1'b1, 32'h0400_0010, 16'hA55A, 2'h3, 1'b0, 6, 1'b0, 1'b0);
      do_req(1'b0, 1'b1, 32'h0400_0020, 16'h5AA5, 2'h3, 1'b0, 10, 1'b0, 1'b0);
    join
    do_req(1'b1, 1'b0, 32'h0400_0010, 16'h0000, 2'h3, 1'b0, 7, 1'b1, 1'b0);
    do_req(1'b0, 1'b0, 32'h0400_0020, 16'h0000, 2'h3, 1'b0, 7, 1'b1, 1'b0);
    // A request in service is never re-granted, so low slips in after the first high access
    fork
      begin
        @(posedge aclk);
        for (k = 0; k < 20; k++) do_req(1'b1, 1'b1, 32'h0400_0040, k[15:0], 2'h3, 1'b0,
            k == 1 ? 9 : 6, 1'b0, 1'b1);
        rq_hi <= '0;
      end
      do_req(1'b0, 1'b0, 32'h0400_0020, 16'h0000, 2'h3, 1'b0, 11, 1'b0, 1'b0);
    join
    axi_rd(esa_pkg::STATUS_OFFSET, 32'h00, esa_pkg::AXI_OKAY);
    final_report();
  end
endmodule : esa_area_ctrl_tb_top
`default_nettype wire
